// ==== logic/clock_ready_reset_generator.sv ====
// clock divider, peripheral clock, reset and ready synchroniser
//
// Functional notes
// [RL1] processor clock is input divided by three, 33% high
// [RL2] alignment clear holds counter cleared, stops counting
// [RL3] counter source is crystal or external frequency
// [RL4] buffered oscillator output always driven
// [RL5] peripheral clock half processor rate, 50% duty
// [RL6] reset request captured on processor clock falling edge
// [RL7] each bus ready counts only when qualified
// [RL8] single-master systems tie qualifiers low
// [RL9] ready_sync_select mode: rise via first then second flop
// [RL10] ready_sync_select mode: fall straight into second flop
// [RL11] sync mode: second flop only, on falling edge
// [RL12] sync select may change any cycle, applied live
// [RL13] single-stage users meet ready setup and hold
// [RL14] open sync select selects single-stage mode
// [RL15] strap low crystal, strap high external frequency
// [RL16] clear resets counters; partner syncs it to input
// [RL17] reset request active low, reset output active high
// [RL18] qualifiers active low, readies active high
// [RL19] peripheral clock toggles on processor clock rise
// [RL20] ready is OR of qualified synchronised requests
//
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module clock_ready_reset_generator (
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [clkgen_pkg::ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // pins
   input wire logic crystal_in_a_i,
   input wire logic ext_freq_in_i,
   input wire logic freq_source_select_i,
   input wire logic clock_align_clear_i,
   input wire logic reset_request_n_i,
   input wire logic ready_sync_select_i,
   input wire logic bus_ready_a_i,
   input wire logic bus_ready_b_i,
   input wire logic ready_qualifier_a_n_i,
   input wire logic ready_qualifier_b_n_i,
   output logic proc_clk_o,
   output logic periph_clk_o,
   output logic osc_buffered_out_o,
   output logic proc_reset_o,
   output logic ready_o
);

   logic [clkgen_pkg::PIN_W-1:0] pin_raw;
   logic [clkgen_pkg::PIN_W-1:0] pin_s;
   logic src_level;
   logic src_prev_r;
   logic src_rise;
   logic align_clear;
   logic sync_select;
   clkgen_pkg::div_phase_t phase_r;
   clkgen_pkg::div_phase_t phase_nxt;
   logic proc_clk_nxt;
   logic clk_rise;
   logic clk_fall;
   logic [clkgen_pkg::READY_CH-1:0] ready_req;
   logic [clkgen_pkg::READY_CH-1:0] ready_ff1_r;
   logic [clkgen_pkg::READY_CH-1:0] ready_ff2_r;
   logic [31:0] ctrl_r;
   logic [31:0] status;
   logic wb_req;

   assign pin_raw = {ready_qualifier_b_n_i, ready_qualifier_a_n_i, bus_ready_b_i, bus_ready_a_i,
                     ready_sync_select_i, reset_request_n_i, clock_align_clear_i,
                     freq_source_select_i, ext_freq_in_i, crystal_in_a_i};

   // sync select resets to one, so an open pin means single-stage mode
   pin_sync #(
      .W(clkgen_pkg::PIN_W),
      .RST_VAL(clkgen_pkg::PIN_RST)
   ) u_pin_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(pin_raw),
      .level_o(pin_s)
   );

   // counter source: crystal when strap low, external input when high
   assign src_level = pin_s[clkgen_pkg::PIN_FREQ_SEL] ? pin_s[clkgen_pkg::PIN_EXT_FREQ] // RL3 RL15
                                                       : pin_s[clkgen_pkg::PIN_XTAL];
   assign src_rise = src_level & ~src_prev_r;
   assign align_clear = pin_s[clkgen_pkg::PIN_ALIGN] | ctrl_r[clkgen_pkg::CTRL_SOFT_ALIGN_BIT];
   assign sync_select = pin_s[clkgen_pkg::PIN_SYNC_SEL]; // RL14

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         src_prev_r <= 1'b0;
      end else begin
         src_prev_r <= src_level;
      end
   end

   // oscillator buffer runs whatever the strap selects
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osc_buffered_out_o <= 1'b0;
      end else begin
         osc_buffered_out_o <= pin_s[clkgen_pkg::PIN_XTAL]; // RL4
      end
   end

   // divide-by-three phase: one high phase in three
   always_comb begin
      phase_nxt = phase_r;
      if (align_clear) begin
         phase_nxt = clkgen_pkg::PH_HIGH; // RL2 RL16
      end else if (src_rise) begin
         unique case (phase_r)
            clkgen_pkg::PH_HIGH: phase_nxt = clkgen_pkg::PH_LOW1; // RL1
            clkgen_pkg::PH_LOW1: phase_nxt = clkgen_pkg::PH_LOW2;
            clkgen_pkg::PH_LOW2: phase_nxt = clkgen_pkg::PH_HIGH;
            default: phase_nxt = clkgen_pkg::PH_HIGH;
         endcase
      end
   end

   // clock stays low while held in alignment
   assign proc_clk_nxt = (phase_nxt == clkgen_pkg::PH_HIGH) & ~align_clear; // RL1 RL2
   assign clk_rise = proc_clk_nxt & ~proc_clk_o;
   assign clk_fall = ~proc_clk_nxt & proc_clk_o;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase_r <= clkgen_pkg::PH_HIGH;
         proc_clk_o <= 1'b0;
      end else begin
         phase_r <= phase_nxt;
         proc_clk_o <= proc_clk_nxt;
      end
   end

   // peripheral clock flips on each processor clock rise
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         periph_clk_o <= 1'b0;
      end else if (clk_rise) begin
         periph_clk_o <= ~periph_clk_o; // RL5 RL19
      end
   end

   // reset request sampled on the processor clock falling edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         proc_reset_o <= 1'b0;
      end else if (clk_fall) begin
         proc_reset_o <= ~pin_s[clkgen_pkg::PIN_RESET_REQ_N]; // RL6 RL17
      end
   end

   // qualified requests: active-low qualifier gates active-high ready
   assign ready_req[0] = pin_s[clkgen_pkg::PIN_READY_A] & ~pin_s[clkgen_pkg::PIN_QUAL_A_N]; // RL7 RL18
   assign ready_req[1] = pin_s[clkgen_pkg::PIN_READY_B] & ~pin_s[clkgen_pkg::PIN_QUAL_B_N]; // RL7 RL18

   // first ready stage, processor clock rising edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ready_ff1_r <= '0;
      end else if (clk_rise) begin
         ready_ff1_r <= ready_req; // RL9
      end
   end

   // second ready stage, processor clock falling edge, mode read live
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ready_ff2_r <= '0;
      end else if (clk_fall) begin
         for (int i = 0; i < clkgen_pkg::READY_CH; i++) begin
            if (sync_select) begin
               ready_ff2_r[i] <= ready_req[i]; // RL11 RL12
            end else begin
               ready_ff2_r[i] <= ready_ff1_r[i] & ready_req[i]; // RL9 RL10 RL12
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ready_o <= 1'b0;
      end else begin
         ready_o <= |ready_ff2_r; // RL20
      end
   end

   // wishbone slave: one wait state, unmapped reads zero
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

   always_comb begin
      status = 32'h0000_0000;
      status[clkgen_pkg::ST_PROC_CLK_BIT] = proc_clk_o;
      status[clkgen_pkg::ST_PERIPH_CLK_BIT] = periph_clk_o;
      status[clkgen_pkg::ST_PROC_RESET_BIT] = proc_reset_o;
      status[clkgen_pkg::ST_READY_BIT] = ready_o;
      status[clkgen_pkg::ST_FREQ_SEL_BIT] = pin_s[clkgen_pkg::PIN_FREQ_SEL];
      status[clkgen_pkg::ST_SYNC_SEL_BIT] = sync_select;
      status[clkgen_pkg::ST_ALIGN_BIT] = align_clear;
      status[clkgen_pkg::ST_PHASE_LSB +: 2] = phase_r;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wb_req && !wb_we_i) begin
         unique case (wb_adr_i)
            clkgen_pkg::CTRL_OFS: wb_dat_o <= ctrl_r;
            clkgen_pkg::STATUS_OFS: wb_dat_o <= status;
            default: wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r <= clkgen_pkg::CTRL_RST;
      end else if (wb_req && wb_we_i && wb_adr_i == clkgen_pkg::CTRL_OFS && wb_sel_i[0]) begin
         ctrl_r[clkgen_pkg::CTRL_SOFT_ALIGN_BIT] <= wb_dat_i[clkgen_pkg::CTRL_SOFT_ALIGN_BIT];
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   property p_div_step;
      phase_r == clkgen_pkg::PH_HIGH && src_rise && !align_clear |=> phase_r == clkgen_pkg::PH_LOW1 && !proc_clk_o;
   endproperty
   a_div_step: assert property (p_div_step) else $error("divider did not leave high phase"); // RL1

   property p_align_hold;
      align_clear |=> phase_r == clkgen_pkg::PH_HIGH && !proc_clk_o;
   endproperty
   a_align_hold: assert property (p_align_hold) else $error("counter ran during alignment clear"); // RL2

   property p_src_idle;
      !src_rise && !align_clear |=> $stable(phase_r);
   endproperty
   a_src_idle: assert property (p_src_idle) else $error("divider moved without source edge"); // RL3

   property p_osc_follow;
      ##1 osc_buffered_out_o == $past(pin_s[clkgen_pkg::PIN_XTAL]);
   endproperty
   a_osc_follow: assert property (p_osc_follow) else $error("oscillator buffer lost crystal"); // RL4

   property p_periph_toggle;
      $rose(proc_clk_o) |-> periph_clk_o != $past(periph_clk_o);
   endproperty
   a_periph_toggle: assert property (p_periph_toggle) else $error("peripheral clock missed toggle"); // RL5

   property p_reset_fall;
      $fell(proc_clk_o) |-> proc_reset_o == !$past(pin_s[clkgen_pkg::PIN_RESET_REQ_N]);
   endproperty
   a_reset_fall: assert property (p_reset_fall) else $error("reset not captured on clock fall"); // RL6

   property p_reset_steady;
      !$fell(proc_clk_o) |-> $stable(proc_reset_o);
   endproperty
   a_reset_steady: assert property (p_reset_steady) else $error("reset changed off falling edge"); // RL6

   property p_two_stage;
      clk_fall && !sync_select && !ready_ff1_r[0] && ready_req[0] |=> !ready_ff2_r[0];
   endproperty
   a_two_stage: assert property (p_two_stage) else $error("ready skipped first stage"); // RL9

   property p_neg_direct;
      clk_fall && !sync_select && !ready_req[0] |=> !ready_ff2_r[0];
   endproperty
   a_neg_direct: assert property (p_neg_direct) else $error("ready fall not direct"); // RL10

   property p_single_stage;
      clk_fall && sync_select |=> ready_ff2_r[1] == $past(ready_req[1]);
   endproperty
   a_single_stage: assert property (p_single_stage) else $error("single-stage ready wrong"); // RL11

   property p_ready_or;
      $rose(ready_o) |-> $past(ready_ff2_r) != '0;
   endproperty
   a_ready_or: assert property (p_ready_or) else $error("ready rose with no request"); // RL20

endmodule : clock_ready_reset_generator

`default_nettype wire

// ==== inc/clkgen_pkg.sv ====
// constants shared by the clock, reset and ready generator
`default_nettype none

package clkgen_pkg;

   // divide-by-three phase, gray coded except the two-bit PH_LOW2 to PH_HIGH wrap
   typedef enum logic [1:0] {
      PH_HIGH = 2'b00,
      PH_LOW1 = 2'b01,
      PH_LOW2 = 2'b11
   } div_phase_t;

   // wishbone register map (byte addresses)
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;

   // control register fields
   localparam int CTRL_SOFT_ALIGN_BIT = 0;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;

   // status register fields
   localparam int ST_PROC_CLK_BIT = 0;
   localparam int ST_PERIPH_CLK_BIT = 1;
   localparam int ST_PROC_RESET_BIT = 2;
   localparam int ST_READY_BIT = 3;
   localparam int ST_FREQ_SEL_BIT = 4;
   localparam int ST_SYNC_SEL_BIT = 5;
   localparam int ST_ALIGN_BIT = 6;
   localparam int ST_PHASE_LSB = 8;

   // pin synchroniser vector layout
   localparam int PIN_W = 10;
   localparam int PIN_XTAL = 0;
   localparam int PIN_EXT_FREQ = 1;
   localparam int PIN_FREQ_SEL = 2;
   localparam int PIN_ALIGN = 3;
   localparam int PIN_RESET_REQ_N = 4;
   localparam int PIN_SYNC_SEL = 5;
   localparam int PIN_READY_A = 6;
   localparam int PIN_READY_B = 7;
   localparam int PIN_QUAL_A_N = 8;
   localparam int PIN_QUAL_B_N = 9;
   // reset request idle high, sync select pulled up, qualifiers idle high
   localparam logic [PIN_W-1:0] PIN_RST = 10'h330;

   localparam int READY_CH = 2;

endpackage : clkgen_pkg

`default_nettype wire

// ==== logic/pin_sync.sv ====
// three-stage synchroniser for a vector of asynchronous pins
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] level_o
);

   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
         s3_r <= RST_VAL;
      end else begin
         s1_r <= pin_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // a bit is accepted once the second and third stage agree
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_o <= RST_VAL;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2_r[i] == s3_r[i]) begin
               level_o[i] <= s3_r[i];
            end
         end
      end
   end

endmodule : pin_sync

`default_nettype wire

// ==== verification/src_partner.sv ====
// far-side sources: crystal, external frequency and alignment clear
`timescale 1ns/100ps
`default_nettype none
module src_partner (
   input wire logic clk_i,
   input wire logic [7:0] xtal_half_i,
   input wire logic [7:0] ext_half_i,
   input wire logic align_req_i,
   output logic crystal_o,
   output logic ext_freq_o,
   output logic align_o
);
   int xc = 0;
   int ec = 0;
   initial begin
      crystal_o = 1'b0;
      ext_freq_o = 1'b0;
      align_o = 1'b0;
   end
   always @(posedge clk_i) begin
      xc <= (xc + 1 >= int'(xtal_half_i)) ? 0 : xc + 1;
      if (xc + 1 >= int'(xtal_half_i)) crystal_o <= ~crystal_o;
      ec <= (ec + 1 >= int'(ext_half_i)) ? 0 : ec + 1;
      if (ec + 1 >= int'(ext_half_i)) begin
         ext_freq_o <= ~ext_freq_o;
         // clear moves only on a rising external frequency edge
         if (!ext_freq_o) align_o <= align_req_i;
      end
   end
endmodule : src_partner
`default_nettype wire

// ==== verification/clock_ready_reset_generator_bench.sv ====
// self-checking bench for the clock, reset and ready generator
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
   $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module clock_ready_reset_generator_bench;
   localparam int XH = 8;
   localparam int EH = 6;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, fsel = 1'b1, rq_n = 1'b1, ssel = 1'b1;
   logic ra = 1'b0, rb = 1'b0, qa_n = 1'b0, qb_n = 1'b1, areq = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [3:0] sel = 4'hf;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] q;
   logic [31:0] rs = 32'h0000_294e;
   wire logic [31:0] dat_o;
   wire logic ack, xtal, ext_freq_in, aclr, pclk, perclk, osc, prst, rdy;
   int err_total = 0;
   int n_compared = 0;
   int n, h, hi;
   logic e;

   initial begin
      forever #5 clk_i = ~clk_i;
   end

   src_partner src_partner_inst (.clk_i(clk_i), .xtal_half_i(8'(XH)), .ext_half_i(8'(EH)),
      .align_req_i(areq), .crystal_o(xtal), .ext_freq_o(ext_freq_in), .align_o(aclr));

   clock_ready_reset_generator clock_ready_reset_generator_inst (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .crystal_in_a_i(xtal), .ext_freq_in_i(ext_freq_in),
      .freq_source_select_i(fsel), .clock_align_clear_i(aclr), .reset_request_n_i(rq_n),
      .ready_sync_select_i(ssel), .bus_ready_a_i(ra), .bus_ready_b_i(rb),
      .ready_qualifier_a_n_i(qa_n), .ready_qualifier_b_n_i(qb_n), .proc_clk_o(pclk),
      .periph_clk_o(perclk), .osc_buffered_out_o(osc), .proc_reset_o(prst), .ready_o(rdy));

   function logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction : rnd

   function automatic logic pick(input int k);
      case (k)
         0: return pclk;
         1: return perclk;
         2: return prst;
         3: return rdy;
         default: return osc;
      endcase
   endfunction : pick

   task automatic summarize();
      $display("compared %0d mismatched %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : summarize

   task automatic wait_for(input int k, input logic v, output int c);
      c = 0;
      while (pick(k) !== v) begin
         @(negedge clk_i);
         c++;
         if (c > 3000) begin
            err_total++;
            summarize();
         end
      end
   endtask : wait_for

   // high time of the chosen output, starting from its next rise
   task automatic span(input int k, output int c);
      wait_for(k, 1'b0, c);
      wait_for(k, 1'b1, c);
      wait_for(k, 1'b0, c);
   endtask : span

   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int c;
      c = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
         c++;
      end while (ack !== 1'b1 && c < 50);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (c >= 50) begin
         err_total++;
         summarize();
      end
   endtask : wb

   task automatic count_high(output int c);
      c = 0;
      repeat (200) begin
         @(negedge clk_i);
         c += (pclk !== 1'b0) ? 1 : 0;
      end
   endtask : count_high

   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      // the divider starts in its high phase, so let that first partial high pass
      repeat (40) @(posedge clk_i);
      span(0, h);
      wait_for(0, 1'b1, n);
      `CHK("proc high", 2 * EH, h)
      `CHK("proc low", 4 * EH, n)
      span(1, h);
      `CHK("periph high", 6 * EH, h)
      wait_for(1, 1'b1, n);
      `CHK("periph edge", 1'b1, pclk)
      span(4, h);
      `CHK("osc high", XH, h)
      @(posedge clk_i);
      fsel <= 1'b0;
      span(0, h);
      span(0, h);
      `CHK("xtal proc high", 2 * XH, h)
      wb(1'b0, 4'h4, 32'h0000_0000);
      `CHK("strap", 1'b0, q[4])
      @(posedge clk_i);
      fsel <= 1'b1;
      areq <= 1'b1;
      repeat (40) @(posedge clk_i);
      count_high(hi);
      `CHK("pin align", 0, hi)
      @(posedge clk_i);
      areq <= 1'b0;
      wait_for(0, 1'b1, n);
      `CHK("align release", 1'b1, n >= 4 * EH && n <= 6 * EH + 8)
      wb(1'b1, 4'h0, 32'h0000_0001);
      repeat (40) @(posedge clk_i);
      wb(1'b0, 4'h4, 32'h0000_0000);
      `CHK("soft align", 4'h2, {q[9:8], q[6], q[0]})
      count_high(hi);
      `CHK("soft hold", 0, hi)
      wb(1'b1, 4'h0, 32'h0000_0000);
      wb(1'b1, 4'hc, 32'hffff_ffff);
      wb(1'b0, 4'h8, 32'h0000_0000);
      `CHK("unmapped", 32'h0000_0000, q)
      // a control write without its low byte enabled must not land
      sel <= 4'he;
      wb(1'b1, 4'h0, 32'h0000_0001);
      sel <= 4'hf;
      wb(1'b0, 4'h0, 32'h0000_0000);
      `CHK("ctrl", 32'h0000_0000, q)
      @(posedge clk_i);
      rq_n <= 1'b0;
      wait_for(2, 1'b1, n);
      `CHK("reset on fall", 1'b0, pclk)
      `CHK("reset soon", 1'b1, n <= 48)
      @(posedge clk_i);
      rq_n <= 1'b1;
      wait_for(2, 1'b0, n);
      `CHK("reset off on fall", 1'b0, pclk)
      for (int i = 0; i < 16; i++) begin
         @(posedge clk_i);
         q = rnd();
         ra <= q[0];
         rb <= q[1];
         qa_n <= q[2];
         qb_n <= q[3];
         ssel <= q[4];
         e = (q[0] & ~q[2]) | (q[1] & ~q[3]);
         repeat (100) @(posedge clk_i);
         @(negedge clk_i);
         `CHK("ready", e, rdy)
         h = int'(q[4]);
         wb(1'b0, 4'h4, 32'h0000_0000);
         `CHK("sync select", h[0], q[5])
      end
      for (int m = 1; m >= 0; m--) begin
         @(posedge clk_i);
         ra <= 1'b0;
         rb <= 1'b0;
         qa_n <= 1'b0;
         ssel <= 1'(m);
         repeat (100) @(posedge clk_i);
         span(0, h);
         wait_for(0, 1'b1, n);
         @(posedge clk_i);
         ra <= 1'b1;
         wait_for(3, 1'b1, n);
         `CHK("rise latency", 1'(m), n < 36)
         `CHK("ready after fall", 1'b0, pclk)
         wait_for(0, 1'b1, n);
         @(posedge clk_i);
         ra <= 1'b0;
         wait_for(3, 1'b0, n);
         `CHK("fall latency", 1'b1, n < 36)
      end
      summarize();
   end
endmodule : clock_ready_reset_generator_bench
`default_nettype wire
